/* File: logic/fcp_map.svh */
// Address map, field positions and reset values of the code guard block.
// Assumes byte addresses of a 22-bit table pointer space.
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH
`define FCP_ADDR_W 22
`define FCP_OFS_RD_GUARD 22'h300008
`define FCP_OFS_BOOT_EE_RD 22'h300009
`define FCP_OFS_WR_GUARD 22'h30000A
`define FCP_OFS_BOOT_EE_CFG_WR 22'h30000B
`define FCP_OFS_XREAD 22'h30000C
`define FCP_OFS_BOOT_XREAD 22'h30000D
`define FCP_CFG_LO 22'h300000
`define FCP_CFG_HI 22'h3000FF
`define FCP_ID_LO 22'h200000
`define FCP_ID_HI 22'h200007
`define FCP_DEVID_LO 22'h3FFFFE
`define FCP_DEVID_HI 22'h3FFFFF
`define FCP_BOOT_MAX 22'h000800
`define FCP_BIT_R0 0
`define FCP_BIT_R1 1
`define FCP_BIT_EE_RD 7
`define FCP_BIT_BOOT_RD 6
`define FCP_BIT_EE_WR 7
`define FCP_BIT_BOOT_WR 6
`define FCP_BIT_CFG_WR 5
`define FCP_BIT_BOOT_XR 6
`define FCP_RST_CFG 8'hFF
`define FCP_RD_GUARD_MASK 8'h03
`define FCP_BOOT_EE_RD_MASK 8'hC0
`define FCP_WR_GUARD_MASK 8'h03
`define FCP_BOOT_EE_CFG_WR_MASK 8'hE0
`define FCP_XREAD_MASK 8'h03
`define FCP_BOOT_XREAD_MASK 8'h40
`endif

/* File: logic/fcp_pkg.sv */
// Types of the code guard block.
// Assumes fcp_map.svh is on the include path.
package fcp_pkg;
  typedef enum logic [1:0] {
    FCP_REG_BOOT = 2'b00,
    FCP_REG_BLK0 = 2'b01,
    FCP_REG_BLK1 = 2'b10,
    FCP_REG_NONE = 2'b11
  } fcp_region_t;
  typedef enum logic [1:0] {
    FCP_ST_IDLE = 2'b00,
    FCP_ST_ERASE = 2'b01,
    FCP_ST_DONE = 2'b10
  } fcp_state_t;
  typedef struct packed {
    logic [2:0] rd;
    logic [2:0] wr;
    logic [2:0] xr;
  } fcp_guard_t;
endpackage

/* File: logic/fcp_guard_if.sv */
// Guard bits and region map passed from the guard store to the checker.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface fcp_guard_if;
  import fcp_pkg::*;
  fcp_guard_t g;
  logic ee_rd;
  logic ee_wr;
  logic cfg_wr;
  logic [21:0] boot_end;
  logic [21:0] blk1_start;
  logic [21:0] mem_end;
  modport store (output g, ee_rd, ee_wr, cfg_wr, boot_end, blk1_start, mem_end);
  modport check (input g, ee_rd, ee_wr, cfg_wr, boot_end, blk1_start, mem_end);
endinterface
`default_nettype wire

/* File: logic/fcp_region.sv */
// Region lookup for one program-memory address.
// Assumes boundaries from the guard interface.
`timescale 1ns/1ps
`default_nettype none
module fcp_region
  import fcp_pkg::*;
(
  input wire logic [21:0] addr_i,
  fcp_guard_if.check gif,
  output var fcp_region_t region_o
);
  // ---------------------------------------------
  // Region decode
  // ---------------------------------------------
  always_comb begin
    if (addr_i < gif.boot_end) begin
      region_o = FCP_REG_BOOT;
    end else if (addr_i < gif.blk1_start) begin
      region_o = FCP_REG_BLK0;
    end else if (addr_i < gif.mem_end) begin
      region_o = FCP_REG_BLK1;
    end else begin
      region_o = FCP_REG_NONE;
    end
  end
endmodule
`default_nettype wire

/* File: logic/fcp_top.sv */
// Code and data memory guard: decides table and programmer access.
// Assumes all requests are synchronous to mclk_i, one per cycle.
`timescale 1ns/1ps
`include "fcp_map.svh"
`default_nettype none
module fcp_top
  import fcp_pkg::*;
#(
  parameter logic [21:0] BOOT_SIZE = 22'h000200,
  parameter logic [21:0] MEM_SIZE = 22'h002000
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic tbl_rd_i,
  input wire logic tbl_wr_i,
  input wire logic [21:0] table_pointer_i,
  input wire logic [21:0] pc_i,
  input wire logic [7:0] tbl_wdata_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic ee_rd_i,
  input wire logic ee_wr_i,
  input wire logic prog_mode_i,
  input wire logic prog_rd_i,
  input wire logic prog_wr_i,
  input wire logic prog_ee_i,
  input wire logic [21:0] prog_addr_i,
  input wire logic [7:0] prog_wdata_i,
  input wire logic prog_chip_erase_i,
  input wire logic prog_blk_erase_i,
  input wire logic prog_row_erase_i,
  input wire logic [1:0] prog_erase_sel_i,
  output logic grant_o,
  output logic deny_o,
  output logic [7:0] tbl_rdata_o,
  output logic erase_go_o,
  output logic erase_busy_o,
  output logic [7:0] guard_rd_o
);
  // ---------------------------------------------
  // Guard storage
  // ---------------------------------------------
  logic [7:0] rd_guard_q;
  logic [7:0] boot_ee_rd_q;
  logic [7:0] wr_guard_q;
  logic [7:0] boot_ee_cfg_wr_q;
  logic [7:0] xread_q;
  logic [7:0] boot_xread_q;
  fcp_state_t state_q;
  fcp_guard_if gif ();
  fcp_region_t ptr_reg;
  fcp_region_t pc_reg;
  fcp_region_t prg_reg;
  assign gif.boot_end = (BOOT_SIZE > `FCP_BOOT_MAX) ? `FCP_BOOT_MAX : BOOT_SIZE;
  assign gif.blk1_start = MEM_SIZE >> 1;
  assign gif.mem_end = MEM_SIZE;
  // One driver for the whole struct; per-member assigns upset some tools
  assign gif.g = '{rd: {rd_guard_q[`FCP_BIT_R1], rd_guard_q[`FCP_BIT_R0], boot_ee_rd_q[`FCP_BIT_BOOT_RD]},
                   wr: {wr_guard_q[`FCP_BIT_R1], wr_guard_q[`FCP_BIT_R0], boot_ee_cfg_wr_q[`FCP_BIT_BOOT_WR]},
                   xr: {xread_q[`FCP_BIT_R1], xread_q[`FCP_BIT_R0], boot_xread_q[`FCP_BIT_BOOT_XR]}};
  assign gif.ee_rd = boot_ee_rd_q[`FCP_BIT_EE_RD];
  assign gif.ee_wr = boot_ee_cfg_wr_q[`FCP_BIT_EE_WR];
  assign gif.cfg_wr = boot_ee_cfg_wr_q[`FCP_BIT_CFG_WR];
  fcp_region u_ptr (.addr_i(table_pointer_i), .gif(gif), .region_o(ptr_reg));
  fcp_region u_pc (.addr_i(pc_i), .gif(gif), .region_o(pc_reg));
  fcp_region u_prg (.addr_i(prog_addr_i), .gif(gif), .region_o(prg_reg));

  // Guard bit of a region; unmapped region reads as unguarded
  function automatic logic pick(input logic [2:0] v, input fcp_region_t r);
    pick = (r == FCP_REG_NONE) ? 1'b1 : v[r];
  endfunction
  function automatic logic in_rng(input logic [21:0] a, input logic [21:0] lo, input logic [21:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // ---------------------------------------------
  // Access decisions
  // ---------------------------------------------
  logic is_cfg;
  logic is_id;
  logic is_devid;
  logic is_pcfg;
  logic cpu_rd_ok;
  logic cpu_wr_ok;
  logic prg_rd_ok;
  logic prg_wr_ok;
  logic cpu_cfg_wr;
  logic prg_cfg_wr;
  logic any_req;
  logic ok;
  assign is_cfg = in_rng(table_pointer_i, `FCP_CFG_LO, `FCP_CFG_HI);
  assign is_id = in_rng(table_pointer_i, `FCP_ID_LO, `FCP_ID_HI);
  assign is_devid = in_rng(table_pointer_i, `FCP_DEVID_LO, `FCP_DEVID_HI);
  assign is_pcfg = in_rng(prog_addr_i, `FCP_CFG_LO, `FCP_CFG_HI);
  // Same region always reads; otherwise cross-read permit decides
  assign cpu_rd_ok = is_cfg || is_id || is_devid ||
                     (ptr_reg == pc_reg) || pick(gif.g.xr, ptr_reg);
  assign cpu_wr_ok = is_cfg ? gif.cfg_wr : (is_id || pick(gif.g.wr, ptr_reg));
  assign prg_rd_ok = prog_ee_i ? gif.ee_rd : (is_pcfg || pick(gif.g.rd, prg_reg));
  assign prg_wr_ok = prog_ee_i ? (gif.ee_rd && gif.ee_wr) :
                     (is_pcfg || (pick(gif.g.rd, prg_reg) && pick(gif.g.wr, prg_reg)));
  assign cpu_cfg_wr = tbl_wr_i && is_cfg && gif.cfg_wr && !prog_mode_i;
  assign prg_cfg_wr = prog_mode_i && prog_wr_i && is_pcfg;
  assign any_req = tbl_rd_i || tbl_wr_i || ee_rd_i || ee_wr_i || prog_rd_i || prog_wr_i;
  always_comb begin
    ok = 1'b1;
    if (prog_rd_i) begin
      ok = prog_mode_i && prg_rd_ok;
    end else if (prog_wr_i) begin
      ok = prog_mode_i && prg_wr_ok;
    end else if (tbl_wr_i) begin
      ok = cpu_wr_ok;
    end else if (tbl_rd_i) begin
      ok = cpu_rd_ok;
    end else if (ee_wr_i) begin
      ok = gif.ee_wr;
    end else if (ee_rd_i) begin
      ok = 1'b1;
    end
  end

  // ---------------------------------------------
  // Answer outputs
  // ---------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      grant_o <= 1'b0;
      deny_o <= 1'b0;
      tbl_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      grant_o <= any_req && ok;
      deny_o <= any_req && !ok;
      // Refused reads return zeros, never stale data
      tbl_rdata_o <= ((tbl_rd_i || prog_rd_i) && ok) ? mem_rdata_i : 8'h00;
    end
  end

  // ---------------------------------------------
  // Erase sequencing, programmer only
  // ---------------------------------------------
  logic erase_req;
  logic row_ok;
  fcp_region_t row_reg;
  assign row_reg = prg_reg;
  // Row erase of a guarded region is refused: block erase needed
  assign row_ok = pick(gif.g.rd, row_reg) && pick(gif.g.wr, row_reg);
  assign erase_req = prog_mode_i && (prog_chip_erase_i || prog_blk_erase_i ||
                     (prog_row_erase_i && row_ok));
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= FCP_ST_IDLE;
    end else if (clk_en_i) begin
      unique case (state_q)
        FCP_ST_IDLE: begin
          if (erase_req) begin
            state_q <= FCP_ST_ERASE;
          end
        end
        FCP_ST_ERASE: begin
          state_q <= FCP_ST_DONE;
        end
        FCP_ST_DONE: begin
          state_q <= FCP_ST_IDLE;
        end
        default: begin
          state_q <= FCP_ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      erase_go_o <= 1'b0;
      erase_busy_o <= 1'b0;
    end else if (clk_en_i) begin
      erase_go_o <= (state_q == FCP_ST_IDLE) && erase_req;
      erase_busy_o <= (state_q == FCP_ST_IDLE) ? erase_req : (state_q == FCP_ST_ERASE);
    end
  end

  // ---------------------------------------------
  // Guard bit update
  // ---------------------------------------------
  // Write can only clear; erase restores ones
  function automatic logic [7:0] clr_only(input logic [7:0] cur, input logic [7:0] wd, input logic [7:0] m);
    clr_only = cur & (wd | ~m);
  endfunction
  logic [7:0] wd;
  logic cfg_wr_en;
  logic chip_er;
  logic [2:0] blk_er;
  assign wd = prog_mode_i ? prog_wdata_i : tbl_wdata_i;
  assign cfg_wr_en = cpu_cfg_wr || prg_cfg_wr;
  assign chip_er = prog_mode_i && prog_chip_erase_i && (state_q == FCP_ST_IDLE);
  always_comb begin
    blk_er = 3'b000;
    if (prog_mode_i && prog_blk_erase_i && (state_q == FCP_ST_IDLE) && (prog_erase_sel_i != 2'b11)) begin
      blk_er[prog_erase_sel_i] = 1'b1;
    end
  end
  logic [21:0] wa;
  assign wa = prog_mode_i ? prog_addr_i : table_pointer_i;
  function automatic logic hit(input logic en, input logic [21:0] a, input logic [21:0] o);
    hit = en && (a == o);
  endfunction
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_guard_q <= `FCP_RST_CFG;
      boot_ee_rd_q <= `FCP_RST_CFG;
      wr_guard_q <= `FCP_RST_CFG;
      boot_ee_cfg_wr_q <= `FCP_RST_CFG;
      xread_q <= `FCP_RST_CFG;
      boot_xread_q <= `FCP_RST_CFG;
    end else if (clk_en_i) begin
      if (chip_er) begin
        rd_guard_q <= `FCP_RST_CFG;
        boot_ee_rd_q <= `FCP_RST_CFG;
        wr_guard_q <= `FCP_RST_CFG;
        boot_ee_cfg_wr_q <= `FCP_RST_CFG;
        xread_q <= `FCP_RST_CFG;
        boot_xread_q <= `FCP_RST_CFG;
      end else if (blk_er != 3'b000) begin
        rd_guard_q[`FCP_BIT_R0] <= rd_guard_q[`FCP_BIT_R0] | blk_er[1];
        rd_guard_q[`FCP_BIT_R1] <= rd_guard_q[`FCP_BIT_R1] | blk_er[2];
        wr_guard_q[`FCP_BIT_R0] <= wr_guard_q[`FCP_BIT_R0] | blk_er[1];
        wr_guard_q[`FCP_BIT_R1] <= wr_guard_q[`FCP_BIT_R1] | blk_er[2];
        xread_q[`FCP_BIT_R0] <= xread_q[`FCP_BIT_R0] | blk_er[1];
        xread_q[`FCP_BIT_R1] <= xread_q[`FCP_BIT_R1] | blk_er[2];
        boot_ee_rd_q[`FCP_BIT_BOOT_RD] <= boot_ee_rd_q[`FCP_BIT_BOOT_RD] | blk_er[0];
        boot_ee_cfg_wr_q[`FCP_BIT_BOOT_WR] <= boot_ee_cfg_wr_q[`FCP_BIT_BOOT_WR] | blk_er[0];
        boot_xread_q[`FCP_BIT_BOOT_XR] <= boot_xread_q[`FCP_BIT_BOOT_XR] | blk_er[0];
      end else begin
        if (hit(cfg_wr_en, wa, `FCP_OFS_RD_GUARD)) begin
          rd_guard_q <= clr_only(rd_guard_q, wd, `FCP_RD_GUARD_MASK);
        end
        if (hit(cfg_wr_en, wa, `FCP_OFS_BOOT_EE_RD)) begin
          boot_ee_rd_q <= clr_only(boot_ee_rd_q, wd, `FCP_BOOT_EE_RD_MASK);
        end
        if (hit(cfg_wr_en, wa, `FCP_OFS_WR_GUARD)) begin
          wr_guard_q <= clr_only(wr_guard_q, wd, `FCP_WR_GUARD_MASK);
        end
        // Config write guard bit stays read-only to the CPU
        if (hit(cfg_wr_en, wa, `FCP_OFS_BOOT_EE_CFG_WR)) begin
          boot_ee_cfg_wr_q <= clr_only(boot_ee_cfg_wr_q, wd,
              prog_mode_i ? `FCP_BOOT_EE_CFG_WR_MASK : 8'hC0);
        end
        if (hit(cfg_wr_en, wa, `FCP_OFS_XREAD)) begin
          xread_q <= clr_only(xread_q, wd, `FCP_XREAD_MASK);
        end
        if (hit(cfg_wr_en, wa, `FCP_OFS_BOOT_XREAD)) begin
          boot_xread_q <= clr_only(boot_xread_q, wd, `FCP_BOOT_XREAD_MASK);
        end
      end
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      guard_rd_o <= 8'h00;
    end else if (clk_en_i) begin
      guard_rd_o <= {1'b0, gif.ee_rd, gif.ee_wr, gif.cfg_wr,
                     gif.g.rd[0], gif.g.wr[0], gif.g.xr[0], &gif.g.xr[2:1]};
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  AST_WR_GUARD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i && tbl_wr_i && !prog_rd_i && !prog_wr_i && !is_cfg && !is_id && ptr_reg != FCP_REG_NONE
    && !gif.g.wr[ptr_reg] |=> deny_o && !grant_o) else $error("table write to guarded region granted");
  AST_SAME_REGION: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i && tbl_rd_i && !tbl_wr_i && !prog_rd_i && !prog_wr_i && ptr_reg == pc_reg |=> grant_o)
    else $error("same-region table read refused");
  AST_FOREIGN_ZERO: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i && tbl_rd_i && !tbl_wr_i && !prog_rd_i && !prog_wr_i && !is_cfg && !is_id && !is_devid
    && ptr_reg != pc_reg && ptr_reg != FCP_REG_NONE && !gif.g.xr[ptr_reg] |=> deny_o && tbl_rdata_o == 8'h00)
    else $error("foreign table read not zeroed");
  AST_ONE_WAY: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !$past(chip_er) && !$past(prog_blk_erase_i) |->
    ({rd_guard_q, boot_ee_rd_q, wr_guard_q, boot_ee_cfg_wr_q, xread_q, boot_xread_q} &
     ~$past({rd_guard_q, boot_ee_rd_q, wr_guard_q, boot_ee_cfg_wr_q, xread_q, boot_xread_q})) == 48'h0)
    else $error("guard bit rose without erase");
  AST_ERASE_SRC: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    erase_go_o |-> $past(prog_mode_i)) else $error("erase started without programmer");
  AST_EE_RD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i && prog_rd_i && prog_ee_i && !gif.ee_rd |=> deny_o) else $error("guarded eeprom read granted");
  AST_EE_WR: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i && ee_wr_i && !tbl_rd_i && !tbl_wr_i && !prog_rd_i && !prog_wr_i && !gif.ee_wr |=> deny_o)
    else $error("guarded eeprom write granted");
  AST_EE_CPU_RD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i && ee_rd_i && !ee_wr_i && !tbl_rd_i && !tbl_wr_i && !prog_rd_i && !prog_wr_i |=> grant_o)
    else $error("cpu eeprom read refused");
  AST_CFG_RO: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !$past(prog_mode_i) && !$past(chip_er) && !$past(prog_blk_erase_i) |-> gif.cfg_wr == $past(gif.cfg_wr))
    else $error("config guard changed by cpu");
  AST_ID_RD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i && tbl_rd_i && is_id && !tbl_wr_i && !prog_rd_i && !prog_wr_i |=> grant_o)
    else $error("id read refused");
  CV_FOREIGN: cover property (@(posedge mclk_i) tbl_rd_i && ptr_reg != pc_reg ##1 deny_o);
  CV_ERASE: cover property (@(posedge mclk_i) erase_go_o ##1 erase_busy_o);
  CV_CFG_WR: cover property (@(posedge mclk_i) prg_cfg_wr);
endmodule
`default_nettype wire

/* File: tb/fcp_prog_model.sv */
// External programmer on the serial programming link, as seen at the guard block.
// Assumes the caller enters each task just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module fcp_prog_model (
  input wire logic mclk_i,
  output logic mode_o,
  output logic rd_o,
  output logic wr_o,
  output logic ee_o,
  output logic chip_o,
  output logic blk_o,
  output logic row_o,
  output logic [1:0] sel_o,
  output logic [21:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    {mode_o, rd_o, wr_o, ee_o, chip_o, blk_o, row_o} = 7'h00;
    sel_o = 2'h3;
    addr_o = 22'h000000;
    wdata_o = 8'h00;
  end
  task automatic set_mode(input logic m);
    mode_o = m;
  endtask
  // One-cycle access; strobes drop, address and data flip so stale values never look valid
  task automatic xfer(input logic rd, input logic wr, input logic ee, input logic [21:0] a, input logic [7:0] d);
    {rd_o, wr_o, ee_o} = {rd, wr, ee};
    addr_o = a;
    wdata_o = d;
    @(negedge mclk_i);
    {rd_o, wr_o, ee_o} = 3'h0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Erase only issued from the link; protected blocks get block erase
  // Row erase picks its region from the address lines, so they are driven too
  task automatic erase(input logic [1:0] kind, input logic [1:0] sel, input logic [21:0] a);
    {chip_o, blk_o, row_o} = (kind == 2'h0) ? 3'h4 : (kind == 2'h1) ? 3'h2 : 3'h1;
    sel_o = sel;
    addr_o = a;
    @(negedge mclk_i);
    {chip_o, blk_o, row_o} = 3'h0;
    sel_o = ~sel;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

/* File: tb/flash_code_protection_test.sv */
// Self-checking bench of the code guard block, random and corner table traffic.
// Assumes fcp_pkg and fcp_map.svh compiled first, default region sizes.
`timescale 1ns/1ps
`default_nettype none
module flash_code_protection_test;
  logic mclk_i, reset_n_i, clk_en_i, tbl_rd_i, tbl_wr_i, ee_rd_i, ee_wr_i;
  logic [21:0] table_pointer_i, pc_i, prog_addr_i;
  logic [7:0] tbl_wdata_i, mem_rdata_i, prog_wdata_i, mem_v, tbl_rdata_o, guard_rd_o;
  logic prog_mode_i, prog_rd_i, prog_wr_i, prog_ee_i, prog_chip_erase_i, prog_blk_erase_i, prog_row_erase_i;
  logic [1:0] prog_erase_sel_i;
  logic grant_o, deny_o, erase_go_o, erase_busy_o;
  logic [2:0] g_rd, g_wr, g_xr;
  logic ee_rd_g, ee_wr_g, cfg_g;
  logic [31:0] seed;
  int n_fail, comparisons;
  // ----------------------------------------
  // Clock, design and programmer
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  fcp_top dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .tbl_rd_i(tbl_rd_i),
    .tbl_wr_i(tbl_wr_i), .table_pointer_i(table_pointer_i), .pc_i(pc_i), .tbl_wdata_i(tbl_wdata_i),
    .mem_rdata_i(mem_rdata_i), .ee_rd_i(ee_rd_i), .ee_wr_i(ee_wr_i), .prog_mode_i(prog_mode_i),
    .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i), .prog_ee_i(prog_ee_i), .prog_addr_i(prog_addr_i),
    .prog_wdata_i(prog_wdata_i), .prog_chip_erase_i(prog_chip_erase_i), .prog_blk_erase_i(prog_blk_erase_i),
    .prog_row_erase_i(prog_row_erase_i), .prog_erase_sel_i(prog_erase_sel_i), .grant_o(grant_o),
    .deny_o(deny_o), .tbl_rdata_o(tbl_rdata_o), .erase_go_o(erase_go_o), .erase_busy_o(erase_busy_o),
    .guard_rd_o(guard_rd_o));
  fcp_prog_model prog_u (.mclk_i(mclk_i), .mode_o(prog_mode_i), .rd_o(prog_rd_i), .wr_o(prog_wr_i),
    .ee_o(prog_ee_i), .chip_o(prog_chip_erase_i), .blk_o(prog_blk_erase_i), .row_o(prog_row_erase_i),
    .sel_o(prog_erase_sel_i), .addr_o(prog_addr_i), .wdata_o(prog_wdata_i));
  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] region(input logic [21:0] a);
    return (a < 22'h000200) ? 2'h0 : (a < 22'h001000) ? 2'h1 : (a < 22'h002000) ? 2'h2 : 2'h3;
  endfunction
  function automatic logic rd_ok(input logic [21:0] p, input logic [21:0] c);
    return (region(p) == 2'h3) || g_xr[region(p)] || (region(c) == region(p));
  endfunction
  function automatic logic wr_ok(input logic [21:0] p);
    return (region(p) == 2'h3) || g_wr[region(p)];
  endfunction
  function automatic logic [7:0] stat();
    return {1'b0, ee_rd_g, ee_wr_g, cfg_g, g_rd[0], g_wr[0], g_xr[0], &g_xr[2:1]};
  endfunction
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // req is {table read, table write, eeprom read, eeprom write}
  task automatic cpu(input logic [3:0] req, input logic [21:0] p, input logic [21:0] c, input logic e);
    seed = lfsr_next(seed);
    mem_v = seed[7:0];
    {tbl_rd_i, tbl_wr_i, ee_rd_i, ee_wr_i} = req;
    table_pointer_i = p;
    pc_i = c;
    mem_rdata_i = mem_v;
    @(negedge mclk_i);
    {tbl_rd_i, tbl_wr_i, ee_rd_i, ee_wr_i} = 4'h0;
    table_pointer_i = ~p;
    mem_rdata_i = ~mem_v;
    chk("grant", grant_o, e);
    chk("deny", deny_o, !e);
    chk("rdata", tbl_rdata_o, (req[3] && e) ? mem_v : 8'h00);
    // Idle cycle so no request line changes twice in one time step
    @(negedge mclk_i);
  endtask
  task automatic rnd_tbl(input int n);
    logic [21:0] cp[5] = '{22'h0001FF, 22'h000200, 22'h000FFF, 22'h001000, 22'h001FFF};
    logic [21:0] cc[5] = '{22'h000200, 22'h0001FF, 22'h001000, 22'h000FFF, 22'h000000};
    logic [21:0] p, c;
    for (int i = 0; i < 5; i++) cpu(4'h8, cp[i], cc[i], rd_ok(cp[i], cc[i]));
    for (int i = 0; i < n; i++) begin
      seed = lfsr_next(seed);
      p = {9'h000, seed[12:0]};
      c = {9'h000, seed[28:16]};
      if (seed[31]) cpu(4'h4, p, c, wr_ok(p));
      else cpu(4'h8, p, c, rd_ok(p, c));
    end
  endtask
  task automatic pacc(input logic rd, input logic ee, input logic [21:0] a, input logic [7:0] d, input logic e);
    prog_u.xfer(rd, ~rd, ee, a, d);
    chk("prog grant", grant_o, e);
    chk("prog deny", deny_o, !e);
    @(negedge mclk_i);
  endtask
  // Guard bytes only lose bits; mirror keeps the same one-way rule
  task automatic pw(input logic [21:0] a, input logic [7:0] d);
    pacc(1'b0, 1'b0, a, d, 1'b1);
    case (a)
      22'h300008: g_rd[2:1] &= d[1:0];
      22'h300009: {ee_rd_g, g_rd[0]} &= d[7:6];
      22'h30000A: g_wr[2:1] &= d[1:0];
      22'h30000B: {ee_wr_g, g_wr[0], cfg_g} &= d[7:5];
      22'h30000C: g_xr[2:1] &= d[1:0];
      22'h30000D: g_xr[0] &= d[6];
      default: ;
    endcase
    chk("guard status", guard_rd_o, stat());
  endtask
  task automatic ers(input logic [1:0] kind, input logic [1:0] sel, input logic e);
    prog_u.erase(kind, sel, (sel == 2'h0) ? 22'h000010 : (sel == 2'h1) ? 22'h000400 : 22'h001400);
    chk("erase go", erase_go_o, e);
    @(negedge mclk_i);
    chk("erase busy", erase_busy_o, e);
    @(negedge mclk_i);
    chk("erase busy end", erase_busy_o, 1'b0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    #(25ns * 20000);
    n_fail++;
    end_of_test();
  end
  initial begin
    {reset_n_i, tbl_rd_i, tbl_wr_i, ee_rd_i, ee_wr_i} = 5'h00;
    clk_en_i = 1'b1;
    table_pointer_i = 22'h000000;
    pc_i = 22'h000000;
    tbl_wdata_i = 8'hFF;
    mem_rdata_i = 8'h00;
    {g_rd, g_wr, g_xr, ee_rd_g, ee_wr_g, cfg_g} = 12'hFFF;
    seed = 32'h5717e74e;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(negedge mclk_i);
    reset_n_i = 1'b1;
    prog_u.set_mode(1'b1);
    rnd_tbl(20);
    cpu(4'h4, 22'h30000D, 22'h000400, 1'b1);
    pw(22'h30000C, 8'h00);
    rnd_tbl(20);
    pw(22'h30000C, 8'hFF);
    pw(22'h30000A, 8'h01);
    pw(22'h30000D, 8'hBF);
    rnd_tbl(30);
    for (int i = 0; i < 8; i++) begin
      cpu(4'h8, 22'h200000 + 22'(i), 22'h001400, 1'b1);
      cpu(4'h4, 22'h200000 + 22'(i), 22'h000100, 1'b1);
    end
    cpu(4'h8, 22'h3FFFFE, 22'h001400, 1'b1);
    // Enable low: an always-granted request must leave the answer frozen
    clk_en_i = 1'b0;
    ee_rd_i = 1'b1;
    @(negedge mclk_i);
    chk("frozen grant", grant_o, 8'h00);
    chk("frozen deny", deny_o, 8'h00);
    ee_rd_i = 1'b0;
    clk_en_i = 1'b1;
    pw(22'h300008, 8'h00);
    pacc(1'b1, 1'b0, 22'h000400, 8'h00, 1'b0);
    pacc(1'b1, 1'b0, 22'h000100, 8'h00, 1'b1);
    cpu(4'h8, 22'h000500, 22'h000400, 1'b1);
    pw(22'h300009, 8'h7F);
    pacc(1'b1, 1'b1, 22'h000010, 8'h00, 1'b0);
    cpu(4'h2, 22'h000010, 22'h000400, 1'b1);
    pw(22'h30000B, 8'h5F);
    cpu(4'h1, 22'h000010, 22'h000400, 1'b0);
    pacc(1'b0, 1'b1, 22'h000010, 8'h00, 1'b0);
    cpu(4'h4, 22'h300000, 22'h000400, 1'b0);
    prog_u.set_mode(1'b0);
    pacc(1'b1, 1'b0, 22'h000100, 8'h00, 1'b0);
    ers(2'h0, 2'h3, 1'b0);
    prog_u.set_mode(1'b1);
    ers(2'h2, 2'h1, 1'b0);
    ers(2'h2, 2'h0, 1'b1);
    ers(2'h1, 2'h1, 1'b1);
    {g_rd[1], g_wr[1], g_xr[1]} = 3'h7;
    chk("guard status", guard_rd_o, stat());
    rnd_tbl(20);
    ers(2'h0, 2'h3, 1'b1);
    {g_rd, g_wr, g_xr, ee_rd_g, ee_wr_g, cfg_g} = 12'hFFF;
    chk("guard status", guard_rd_o, stat());
    cpu(4'h1, 22'h000010, 22'h000400, 1'b1);
    // CPU config write clears its bits but never the config write guard
    prog_u.set_mode(1'b0);
    tbl_wdata_i = 8'h00;
    cpu(4'h4, 22'h30000B, 22'h000400, 1'b1);
    {ee_wr_g, g_wr[0]} = 2'b00;
    chk("guard status", guard_rd_o, stat());
    rnd_tbl(20);
    end_of_test();
  end
endmodule
`default_nettype wire
